// [rrx_exec.sv]
`include "rrx_regs.svh"
`default_nettype none

module rrx_exec (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire rrx_pkg::rrx_instr_t instr,
  output logic instr_ready,
  input wire logic [`RRX_PC_W-1:0] top_of_stack,
  output logic stack_pop,
  output logic [`RRX_FADDR_W-1:0] file_addr,
  input wire logic [`RRX_DATA_W-1:0] file_rdata,
  output rrx_pkg::rrx_fwr_t file_wr,
  input wire logic irq_taken,
  output logic [`RRX_PC_W-1:0] pc,
  output logic [`RRX_DATA_W-1:0] working_reg,
  output logic carry,
  output logic [`RRX_DATA_W-1:0] interrupt_control_reg,
  output logic done
);
  import rrx_pkg::*;

  rrx_state_t state_ff, nxt_state; // execution phase
  logic [`RRX_PC_W-1:0] pc_ff, nxt_pc; // program counter
  logic [`RRX_DATA_W-1:0] w_ff, nxt_w; // working register
  logic carry_ff, nxt_carry; // status carry
  logic glb_en_ff, nxt_glb_en; // global_interrupt_enable
  logic pop_ff, nxt_pop; // one-cycle stack pop strobe
  logic done_ff, nxt_done; // one-cycle completion strobe
  rrx_fwr_t fwr_ff, nxt_fwr; // registered file write-back
  logic fire; // instruction accepted this cycle
  logic [`RRX_DATA_W-1:0] rot; // rotate result

  // only accept in the first phase; the second phase of a return is the refill slot
  assign instr_ready = (state_ff == rrx_st_idle);
  assign fire = instr_valid && instr_ready;
  // read address is combinational so rotate finishes in its own cycle
  assign file_addr = instr.file_addr;
  // old carry enters bit 0, old bit 7 leaves towards carry
  assign rot = {file_rdata[`RRX_DATA_W-2:0], carry_ff}; // see RULE7

  assign pc = pc_ff;
  assign working_reg = w_ff;
  assign carry = carry_ff;
  assign stack_pop = pop_ff;
  assign file_wr = fwr_ff;
  assign done = done_ff;

  // only the enable bit lives here; other control bits read as zero
  always_comb begin
    interrupt_control_reg = '0;
    interrupt_control_reg[`RRX_GLB_EN_BIT] = glb_en_ff; // see RULE2
  end

  // next-state computation for all execution state
  always_comb begin
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    nxt_w = w_ff;
    nxt_carry = carry_ff;
    nxt_glb_en = glb_en_ff;
    nxt_pop = 1'b0;
    nxt_done = 1'b0;
    nxt_fwr = '0;
    // interrupt entry clears the enable; a same-cycle interrupt return sets it again below
    if (irq_taken) begin
      nxt_glb_en = 1'b0;
    end
    case (state_ff)
      rrx_st_idle: begin
        if (fire) begin
          case (instr.op)
            return_from_interrupt_op: begin
              nxt_pc = top_of_stack; // see RULE1
              nxt_pop = 1'b1; // see RULE1
              nxt_glb_en = 1'b1; // see RULE2
              // carry is not assigned on any return, see RULE10
              nxt_state = rrx_st_second; // see RULE3
            end
            return_op: begin
              // enable untouched, flags untouched, see RULE10
              nxt_pc = top_of_stack; // see RULE4
              nxt_pop = 1'b1; // see RULE4
              nxt_state = rrx_st_second; // see RULE4
            end
            return_with_literal_op: begin
              // only w and pc move; status flags stay, see RULE10
              nxt_w = instr.literal; // see RULE5
              nxt_pc = top_of_stack; // see RULE5
              nxt_pop = 1'b1; // see RULE5
              nxt_state = rrx_st_second; // see RULE6
            end
            rotate_left_carry_op: begin
              nxt_carry = file_rdata[`RRX_DATA_W-1]; // see RULE7
              if (instr.dest == `RRX_DEST_W) begin
                nxt_w = rot; // see RULE8
              end else begin
                nxt_fwr = '{we: 1'b1, addr: instr.file_addr, data: rot}; // see RULE8
              end
              nxt_done = 1'b1; // see RULE9
            end
            default: begin
              nxt_state = rrx_st_idle;
            end
          endcase
        end
      end
      rrx_st_second: begin
        // fetched word after a return is discarded, so this cycle does nothing else
        nxt_state = rrx_st_idle; // see RULE3
        nxt_done = 1'b1; // see RULE6
      end
      default: begin
        nxt_state = rrx_st_idle;
      end
    endcase
  end

  // registers only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= rrx_st_idle;
      pc_ff <= `RRX_PC_RST;
      w_ff <= `RRX_W_RST;
      carry_ff <= `RRX_CARRY_RST;
      glb_en_ff <= `RRX_GLB_EN_RST;
      pop_ff <= 1'b0;
      done_ff <= 1'b0;
      fwr_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      w_ff <= nxt_w;
      carry_ff <= nxt_carry;
      glb_en_ff <= nxt_glb_en;
      pop_ff <= nxt_pop;
      done_ff <= nxt_done;
      fwr_ff <= nxt_fwr;
    end
  end

  // checks on the design's own outputs
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // any of the three returns accepted
  sequence s_ret_fire;
    fire && (instr.op != rotate_left_carry_op);
  endsequence

  // a return: busy slot, then completion with ready back
  sequence s_two_cycle;
    (!instr_ready && !done) ##1 (done && instr_ready);
  endsequence

  a_int_ret_pc: assert property ( // see RULE1
    fire && instr.op == return_from_interrupt_op |=>
      pc == $past(top_of_stack) && stack_pop)
    else $error("interrupt return did not load pc from stack");

  a_int_ret_enable: assert property ( // see RULE2
    fire && instr.op == return_from_interrupt_op |=>
      interrupt_control_reg[`RRX_GLB_EN_BIT]
      ##1 (interrupt_control_reg[`RRX_GLB_EN_BIT] || $past(irq_taken)))
    else $error("interrupt return did not set the enable");

  a_int_ret_cycles: assert property ( // see RULE3
    fire && instr.op == return_from_interrupt_op |=> s_two_cycle)
    else $error("interrupt return not two cycles");

  a_sub_ret_enable: assert property ( // see RULE4
    fire && instr.op == return_op && !irq_taken |=>
      $stable(interrupt_control_reg) && pc == $past(top_of_stack) ##0 s_two_cycle)
    else $error("subroutine return wrong");

  a_lit_ret_load: assert property ( // see RULE5
    fire && instr.op == return_with_literal_op |=>
      working_reg == $past(instr.literal) && pc == $past(top_of_stack) && stack_pop)
    else $error("literal return loaded wrong values");

  a_lit_ret_cycles: assert property ( // see RULE6
    fire && instr.op == return_with_literal_op |=> stack_pop ##1 (done && !stack_pop))
    else $error("literal return not two cycles");

  a_rotate_result: assert property ( // see RULE7
    fire && instr.op == rotate_left_carry_op && instr.dest == `RRX_DEST_W |=>
      carry == $past(file_rdata[`RRX_DATA_W-1])
      && working_reg == {$past(file_rdata[`RRX_DATA_W-2:0]), $past(carry)})
    else $error("rotate result or carry wrong");

  a_rotate_dest_f: assert property ( // see RULE8
    fire && instr.op == rotate_left_carry_op && instr.dest == `RRX_DEST_F |=>
      file_wr.we && file_wr.addr == $past(instr.file_addr) && $stable(working_reg)
      && file_wr.data == {$past(file_rdata[`RRX_DATA_W-2:0]), $past(carry)})
    else $error("rotate write-back to file wrong");

  a_rotate_one_cycle: assert property ( // see RULE9
    fire && instr.op == rotate_left_carry_op |=> done && instr_ready && !stack_pop)
    else $error("rotate not single cycle");

  a_return_carry_kept: assert property ( // see RULE10
    s_ret_fire |=> $stable(carry) [*2])
    else $error("return changed carry");

  // an interrupt entry in the same cycle must not undo the return's set
  a_int_ret_wins: assert property ( // see RULE2
    fire && instr.op == return_from_interrupt_op && irq_taken |=>
      interrupt_control_reg[`RRX_GLB_EN_BIT])
    else $error("interrupt entry overrode the enable set by a return");

  // one pop per return: the strobe never stands two cycles
  a_pop_single: assert property ( // see RULE1
    stack_pop |=> !stack_pop)
    else $error("stack pop held for more than one cycle");

  // the second cycle of a return is a dead slot: nothing taken, nothing written
  a_busy_refuse: assert property ( // see RULE3
    s_ret_fire |=> !instr_ready && !done && !file_wr.we)
    else $error("return second cycle not idle");

endmodule

`default_nettype wire

// [rrx_regs.svh]
// What this block does
// RULE1 - interrupt return pops stack into program counter
// RULE2 - interrupt return sets global interrupt enable bit
// RULE3 - interrupt return: one word, two cycles
// RULE4 - subroutine return pops stack, two cycles, enable untouched
// RULE5 - literal return loads working register, pops stack
// RULE6 - literal return: one word, two cycles
// RULE7 - rotate left through carry, only carry changes
// RULE8 - file address selects source, destination bit selects target
// RULE9 - rotate: one word, one cycle
// RULE10 - returns leave carry, digit carry, zero alone
`ifndef RRX_REGS_SVH
`define RRX_REGS_SVH

// program counter width, enough for the linear program space
`define RRX_PC_W 15
// working register, literal and file data width
`define RRX_DATA_W 8
// file register address width
`define RRX_FADDR_W 7
// position of the global enable in the interrupt control register
`define RRX_GLB_EN_BIT 7
// reset values
`define RRX_PC_RST 15'h0000
`define RRX_W_RST 8'h00
`define RRX_CARRY_RST 1'b0
`define RRX_GLB_EN_RST 1'b0
// destination select encodings
`define RRX_DEST_W 1'b0
`define RRX_DEST_F 1'b1

`endif

// [rrx_pkg.sv]
`include "rrx_regs.svh"
`default_nettype none

package rrx_pkg;
  // operations this executor understands
  typedef enum logic [1:0] {
    return_from_interrupt_op,
    return_op,
    return_with_literal_op,
    rotate_left_carry_op
  } rrx_op_t;

  // one decoded program word
  typedef struct packed {
    rrx_op_t op;
    logic [`RRX_DATA_W-1:0] literal;
    logic [`RRX_FADDR_W-1:0] file_addr;
    logic dest;
  } rrx_instr_t;

  // write-back request to the file register space
  typedef struct packed {
    logic we;
    logic [`RRX_FADDR_W-1:0] addr;
    logic [`RRX_DATA_W-1:0] data;
  } rrx_fwr_t;

  // execution phase
  typedef enum logic {
    rrx_st_idle,
    rrx_st_second
  } rrx_state_t;
endpackage

`default_nettype wire

// [return_rotate_exec_test.sv]
`include "rrx_regs.svh"
`default_nettype none

module return_rotate_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rrx_pkg::*;
  logic mclk, reset_n, instr_valid, irq_taken, instr_ready, stack_pop, carry, done;
  rrx_instr_t instr;
  rrx_fwr_t file_wr;
  logic [`RRX_PC_W-1:0] top_of_stack, pc;
  logic [`RRX_FADDR_W-1:0] file_addr;
  logic [7:0] file_rdata, working_reg, interrupt_control_reg;
  int error_cnt, check_count;
  // expected architectural state, kept by the bench
  logic [7:0] exp_w, exp_ic;
  logic exp_c;

  rrx_exec rrx_exec_inst (.mclk(mclk), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr(instr), .instr_ready(instr_ready), .top_of_stack(top_of_stack),
    .stack_pop(stack_pop), .file_addr(file_addr), .file_rdata(file_rdata),
    .file_wr(file_wr), .irq_taken(irq_taken), .pc(pc), .working_reg(working_reg),
    .carry(carry), .interrupt_control_reg(interrupt_control_reg), .done(done));

  // 200 mhz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // present one word for a single accept edge, return at the next falling edge
  task automatic issue(input rrx_op_t op, input logic [7:0] lit, input logic [6:0] fa,
                       input logic d);
    instr = '{op, lit, fa, d};
    instr_valid = 1'b1;
    chk("ready_idle", 16'h1, instr_ready);
    @(posedge mclk);
    @(negedge mclk);
    instr_valid = 1'b0;
  endtask

  // any return: pop, pc load, two cycles, flags per op
  task automatic run_ret(input rrx_op_t op, input logic [7:0] lit,
                         input logic [14:0] ret_addr);
    top_of_stack = ret_addr;
    issue(op, lit, 7'h00, 1'b0);
    if (op == return_from_interrupt_op) exp_ic = 8'h80;
    if (op == return_with_literal_op) exp_w = lit;
    chk("pc", {1'b0, ret_addr}, {1'b0, pc});
    chk("pop", 16'h1, stack_pop);
    chk("ready_c1", 16'h0, instr_ready);
    chk("done_c1", 16'h0, done);
    chk("w", exp_w, working_reg);
    chk("int_ctrl", exp_ic, interrupt_control_reg);
    chk("carry", exp_c, carry);
    @(negedge mclk);
    chk("done_c2", 16'h1, done);
    chk("pop_c2", 16'h0, stack_pop);
    chk("ready_c2", 16'h1, instr_ready);
    @(negedge mclk);
    chk("done_c3", 16'h0, done);
  endtask

  // rotate left through carry, one cycle, dest picks w or file
  task automatic run_rot(input logic [6:0] fa, input logic d, input logic [7:0] rd);
    logic [7:0] res;
    res = {rd[6:0], exp_c};
    file_rdata = rd;
    issue(rotate_left_carry_op, 8'h00, fa, d);
    // the word still stands, so the read address still shows its field
    chk("faddr", {9'h0, fa}, {9'h0, file_addr});
    exp_c = rd[7];
    if (!d) exp_w = res;
    chk("done_rot", 16'h1, done);
    chk("carry_rot", exp_c, carry);
    chk("w_rot", exp_w, working_reg);
    chk("we", d, file_wr.we);
    if (d) chk("wdata", {1'b0, fa, res}, {1'b0, file_wr.addr, file_wr.data});
    chk("int_ctrl_rot", exp_ic, interrupt_control_reg);
    @(negedge mclk);
    chk("done_drop", 16'h0, done);
  endtask

  task automatic test_returns;
    run_ret(return_from_interrupt_op, 8'h00, 15'h7fff);
    run_ret(return_op, 8'h00, 15'h0001);
    irq_taken = 1'b1;
    @(negedge mclk);
    irq_taken = 1'b0;
    exp_ic = 8'h00;
    run_ret(return_op, 8'h00, 15'h4000);
    run_ret(return_with_literal_op, 8'hff, 15'h1234);
    run_ret(return_with_literal_op, 8'h00, 15'h0000);
    $display("test_returns finished");
  endtask

  task automatic test_rotate;
    run_rot(7'h00, 1'b0, 8'he6);
    run_rot(7'h7f, 1'b1, 8'h01);
    run_rot(7'h2a, 1'b0, 8'h80);
    run_ret(return_from_interrupt_op, 8'h00, 15'h0abc);
    $display("test_rotate finished");
  endtask

  // interrupt entry and interrupt return in one cycle: the return's set wins
  task automatic test_set_wins;
    top_of_stack = 15'h0155;
    irq_taken = 1'b1;
    issue(return_from_interrupt_op, 8'h00, 7'h00, 1'b0);
    irq_taken = 1'b0;
    chk("int_ctrl_win", 16'h0080, interrupt_control_reg);
    chk("pc_win", 16'h0155, {1'b0, pc});
    repeat (2) @(negedge mclk);
    chk("ready_win", 16'h1, instr_ready);
    $display("test_set_wins finished");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // watchdog: the tests need well under 100 cycles
  initial begin
    #5000;
    error_cnt++;
    test_done();
  end

  initial begin
    reset_n = 1'b0;
    instr_valid = 1'b0;
    irq_taken = 1'b0;
    instr = '0;
    top_of_stack = '0;
    file_rdata = 8'h00;
    exp_w = 8'h00;
    exp_ic = 8'h00;
    exp_c = 1'b0;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    reset_n = 1'b1;
    chk("pc_rst", 16'h0, {1'b0, pc});
    chk("ic_rst", 16'h0, interrupt_control_reg);
    test_returns();
    test_rotate();
    test_set_wins();
    test_done();
  end
endmodule

`default_nettype wire
